// File: logic/sbs_top.sv
// Synchronous burst SRAM control block with array and register slave
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module sbs_top #(
   parameter int ADDR_W = sbs_pkg::ADDR_W,
   parameter int LANES  = sbs_pkg::LANES,
   parameter int LANE_W = sbs_pkg::LANE_W
) (
   // Clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // Address and cycle controls
   input  wire logic [ADDR_W-1:0]       addr,
   input  wire logic                    chip_select_low,
   input  wire logic                    chip_select_high,
   input  wire logic                    proc_addr_strobe_n,
   input  wire logic                    ctrl_addr_strobe_n,
   input  wire logic                    burst_step_n,
   // Write controls
   input  wire logic                    global_write_n,
   input  wire logic                    byte_write_enable_n,
   input  wire logic [LANES-1:0]        lane_enable_n,
   // Output enable and mode pins
   input  wire logic                    output_enable_n,
   input  wire logic                    linear_order_n,
   input  wire logic                    flow_through_select_n,
   input  wire logic                    sleep_request,
   // Data bus, split into input, output and enable
   input  wire logic [LANES*LANE_W-1:0] data_in,
   output logic      [LANES*LANE_W-1:0] data_out,
   output logic      [LANES-1:0]        data_oe_n,
   // AXI4-Lite write channels
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic      [1:0]              s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);
   localparam int AW = sbs_pkg::AXI_AW;
   localparam int WL = sbs_pkg::WORD_LSB;
   sbs_burst_if burst ();
   sbs_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) mem ();
   sbs_pkg::sbs_cycle_t next_cycle;
   sbs_pkg::sbs_cycle_t last_cycle;
   logic                selected;
   logic                sleeping;
   logic                force_sleep;
   logic                wr_decode;
   logic [LANES-1:0]    lane_we;
   logic                is_read;
   logic                is_write;
   logic [ADDR_W-3:0]   addr_hi;
   logic [ADDR_W-1:0]   acc_addr;
   logic                rd_flow;
   logic                rd_pipe;
   logic [LANES*LANE_W-1:0] pipe_q;
   logic                drive;
   // Both chip selects must agree
   assign selected = ~chip_select_low & chip_select_high;
   // Mode pins default by pad pull devices when left open
   assign sleeping = sleep_request | force_sleep;
   // Write decode; lanes above the build width do not exist
   always_comb begin
      if (!global_write_n) begin
         lane_we = '1;
      end else if (!byte_write_enable_n) begin
         lane_we = ~lane_enable_n;
      end else begin
         lane_we = '0;
      end
   end
   assign wr_decode = |lane_we;

   // Cycle decode, every input combination lands on a cycle
   always_comb begin
      if (sleeping) begin
         next_cycle = sbs_pkg::CYC_IDLE;
      end else if (!ctrl_addr_strobe_n && !selected) begin
         next_cycle = sbs_pkg::CYC_DESEL;
      end else if (selected && !proc_addr_strobe_n) begin
         next_cycle = sbs_pkg::CYC_RD_EXT;
      end else if (selected && !ctrl_addr_strobe_n) begin
         next_cycle = wr_decode ? sbs_pkg::CYC_WR_EXT
                                : sbs_pkg::CYC_RD_EXT;
      end else if (!burst_step_n) begin
         next_cycle = wr_decode ? sbs_pkg::CYC_WR_NXT
                                : sbs_pkg::CYC_RD_NXT;
      end else begin
         next_cycle = wr_decode ? sbs_pkg::CYC_WR_CUR
                                : sbs_pkg::CYC_RD_CUR;
      end
   end

   // Access address and array strobes
   always_comb begin
      acc_addr = {addr_hi, burst.lsb};
      is_read  = 1'b0;
      is_write = 1'b0;
      unique case (next_cycle)
         sbs_pkg::CYC_IDLE,
         sbs_pkg::CYC_DESEL: begin
            acc_addr = addr;
         end
         sbs_pkg::CYC_RD_EXT: begin
            acc_addr = addr;
            is_read  = 1'b1;
         end
         sbs_pkg::CYC_WR_EXT: begin
            acc_addr = addr;
            is_write = 1'b1;
         end
         sbs_pkg::CYC_RD_NXT: begin
            acc_addr = {addr_hi, burst.next_lsb};
            is_read  = 1'b1;
         end
         sbs_pkg::CYC_WR_NXT: begin
            acc_addr = {addr_hi, burst.next_lsb};
            is_write = 1'b1;
         end
         sbs_pkg::CYC_RD_CUR: begin
            is_read  = 1'b1;
         end
         sbs_pkg::CYC_WR_CUR: begin
            is_write = 1'b1;
         end
      endcase
   end

   // Counter moves on reads whatever the output enable shows
   assign burst.load     = (next_cycle == sbs_pkg::CYC_RD_EXT) ||
                           (next_cycle == sbs_pkg::CYC_WR_EXT);
   assign burst.step     = (next_cycle == sbs_pkg::CYC_RD_NXT) ||
                           (next_cycle == sbs_pkg::CYC_WR_NXT);
   assign burst.base_lsb = addr[1:0];
   assign burst.linear_n = linear_order_n;
   assign mem.re    = is_read;
   assign mem.we    = is_write ? lane_we : '0;
   assign mem.addr  = acc_addr;
   assign mem.wdata = data_in;
   sbs_burst u_burst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (burst)
   );
   sbs_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .aclk    (aclk),
      .aresetn (aresetn),
      .port    (mem)
   );

   // Upper address held for the whole burst
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_hi <= '0;
      end else if (burst.load) begin
         addr_hi <= addr[ADDR_W-1:2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_cycle <= sbs_pkg::CYC_IDLE;
      end else begin
         last_cycle <= next_cycle;
      end
   end

   // Read valid per stage; writes, deselects and sleep cut both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_flow <= 1'b0;
         rd_pipe <= 1'b0;
      end else begin
         rd_flow <= is_read;
         rd_pipe <= rd_flow & is_read;
      end
   end

   // Output register of the pipeline path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pipe_q <= '0;
      end else begin
         pipe_q <= mem.rdata;
      end
   end

   assign data_out = flow_through_select_n ? pipe_q
                                           : mem.rdata;
   assign drive    = flow_through_select_n ? rd_pipe : rd_flow;
   // Output enable gates at once, never turns drivers on itself
   assign data_oe_n = {LANES{~(drive & ~output_enable_n)}};

   // Register slave, write path
   logic          aw_held;
   logic [AW-1:0] aw_addr;
   logic          w_held;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          do_write;
   logic          wr_ctrl;
   logic [31:0]   status;
   logic [31:0]   rd_word;
   logic [1:0]    rd_resp;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;
   assign wr_ctrl       = aw_addr[AW-1:WL] == sbs_pkg::OFF_CTRL[AW-1:WL];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sbs_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_ctrl || aw_addr[AW-1:WL] ==
                          sbs_pkg::OFF_STATUS[AW-1:WL]) ?
                         sbs_pkg::RESP_OKAY : sbs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software sleep joins the sleep pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_sleep <= sbs_pkg::CTRL_SLEEP_RESET;
      end else if (do_write && wr_ctrl && w_strb[0]) begin
         force_sleep <= w_data[sbs_pkg::CTRL_SLEEP_BIT];
      end
   end

   // Register slave, read path
   always_comb begin
      status = '0;
      status[sbs_pkg::ST_LSB_LO +: 2] = burst.lsb;
      status[sbs_pkg::ST_CNT_LO +: 2] = burst.count;
      status[sbs_pkg::ST_LINEAR_BIT]  = linear_order_n;
      status[sbs_pkg::ST_FLOW_BIT]    = flow_through_select_n;
      status[sbs_pkg::ST_SLEEP_BIT]   = sleeping;
      status[sbs_pkg::ST_DRIVE_BIT]   = drive;
      status[sbs_pkg::ST_CYC_LO +: 3] = last_cycle;
   end

   always_comb begin
      rd_word = '0;
      rd_resp = sbs_pkg::RESP_OKAY;
      if (s_axi_araddr[AW-1:WL] == sbs_pkg::OFF_CTRL[AW-1:WL]) begin
         rd_word[sbs_pkg::CTRL_SLEEP_BIT] = force_sleep;
      end else if (s_axi_araddr[AW-1:WL] ==
                   sbs_pkg::OFF_STATUS[AW-1:WL]) begin
         rd_word = status;
      end else begin
         rd_resp = sbs_pkg::RESP_SLVERR;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= sbs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // sbs_top

// File: pkg/sbs_pkg.sv
// Shared constants and types of the synchronous burst SRAM control block
package sbs_pkg;
   // Array shape
   localparam int ADDR_W = 18;
   localparam int LANES  = 4;
   localparam int LANE_W = 9;

   // Register bus
   localparam int         AXI_AW   = 8;
   localparam int         WORD_LSB = 2;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register fields
   localparam int   CTRL_SLEEP_BIT   = 0;
   localparam logic CTRL_SLEEP_RESET = 1'b0;

   // Status register fields
   localparam int ST_LSB_LO     = 0;
   localparam int ST_CNT_LO     = 2;
   localparam int ST_LINEAR_BIT = 4;
   localparam int ST_FLOW_BIT   = 5;
   localparam int ST_SLEEP_BIT  = 6;
   localparam int ST_DRIVE_BIT  = 7;
   localparam int ST_CYC_LO     = 8;
   localparam int ST_USED       = 11;

   // Burst counter
   localparam logic [1:0] BURST_ZERO = 2'h0;
   localparam logic [1:0] BURST_ONE  = 2'h1;

   // Cycle taken at a clock edge
   typedef enum logic [2:0] {
      CYC_IDLE   = 3'b000,
      CYC_DESEL  = 3'b001,
      CYC_RD_EXT = 3'b010,
      CYC_WR_EXT = 3'b011,
      CYC_RD_NXT = 3'b100,
      CYC_WR_NXT = 3'b101,
      CYC_RD_CUR = 3'b110,
      CYC_WR_CUR = 3'b111
   } sbs_cycle_t;
endpackage

// File: pkg/sbs_ifs.sv
// Interfaces between the control block, its burst counter and its array
interface sbs_burst_if;
   logic       load;
   logic       step;
   logic       linear_n;
   logic [1:0] base_lsb;
   logic [1:0] lsb;
   logic [1:0] next_lsb;
   logic [1:0] count;
   modport ctl (output load, step, linear_n, base_lsb,
                input  lsb, next_lsb, count);
   modport cnt (input  load, step, linear_n, base_lsb,
                output lsb, next_lsb, count);
endinterface

interface sbs_mem_if #(parameter int ADDR_W = 18,
                       parameter int LANES  = 4,
                       parameter int LANE_W = 9);
   logic [LANES-1:0]        we;
   logic                    re;
   logic [ADDR_W-1:0]       addr;
   logic [LANES*LANE_W-1:0] wdata;
   logic [LANES*LANE_W-1:0] rdata;
   modport ctl (output we, re, addr, wdata, input rdata);
   modport mem (input we, re, addr, wdata, output rdata);
endinterface

// File: logic/sbs_burst.sv
// Two-bit burst address counter, linear or interleaved order
module sbs_burst (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control side
   sbs_burst_if.cnt bus
);
   logic [1:0] base;
   logic [1:0] count;
   logic [1:0] next_count;

   assign next_count = count + sbs_pkg::BURST_ONE;

   // Linear adds, interleaved xors; four steps wrap to the start
   assign bus.lsb      = bus.linear_n ? (base ^ count)
                                      : (base + count);
   assign bus.next_lsb = bus.linear_n ? (base ^ next_count)
                                      : (base + next_count);
   assign bus.count    = count;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base  <= sbs_pkg::BURST_ZERO;
         count <= sbs_pkg::BURST_ZERO;
      end else if (bus.load) begin
         base  <= bus.base_lsb;
         count <= sbs_pkg::BURST_ZERO;
      end else if (bus.step) begin
         count <= next_count;
      end
   end
endmodule // sbs_burst

// File: logic/sbs_mem.sv
// Byte-lane writable array with registered read data
module sbs_mem #(
   parameter int ADDR_W = sbs_pkg::ADDR_W,
   parameter int LANES  = sbs_pkg::LANES,
   parameter int LANE_W = sbs_pkg::LANE_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Access port
   sbs_mem_if.mem   port
);
   logic [LANES*LANE_W-1:0] rdata;

   assign port.rdata = rdata;

   // One array per lane, so every lane has a single writer
   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         logic [LANE_W-1:0] store [0:(1<<ADDR_W)-1];

         always_ff @(posedge aclk) begin
            if (port.we[i]) begin
               store[port.addr] <= port.wdata[i*LANE_W +: LANE_W];
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               rdata[i*LANE_W +: LANE_W] <= '0;
            end else if (port.re) begin
               rdata[i*LANE_W +: LANE_W] <= store[port.addr];
            end
         end
      end
   endgenerate
endmodule // sbs_mem

// File: verif/sbs_checker.sv
// Concurrent checks on the pins of the burst SRAM control block
module sbs_checker #(
   parameter int LANES = 4
) (
   // Clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // Cycle and write controls
   input wire logic             chip_select_low,
   input wire logic             chip_select_high,
   input wire logic             proc_addr_strobe_n,
   input wire logic             ctrl_addr_strobe_n,
   input wire logic             global_write_n,
   input wire logic             byte_write_enable_n,
   input wire logic [LANES-1:0] lane_enable_n,
   // Output enable, modes and drivers
   input wire logic             output_enable_n,
   input wire logic             flow_through_select_n,
   input wire logic             sleep_request,
   input wire logic [LANES-1:0] data_oe_n,
   // Register bus
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sel;
   logic wdec;
   logic desel;
   logic wr;
   logic rdx;

   assign sel   = !chip_select_low && chip_select_high;
   assign wdec  = !global_write_n
                  || (!byte_write_enable_n && !(&lane_enable_n));
   assign desel = !ctrl_addr_strobe_n && !sel;
   assign wr    = wdec && !desel && !(sel && !proc_addr_strobe_n);
   assign rdx   = sel && !proc_addr_strobe_n && !sleep_request;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_desel_off: assert property (desel |=> &data_oe_n)
      else $error("drivers on after deselect");
   chk_write_off: assert property (wr |=> &data_oe_n)
      else $error("drivers on after write");
   chk_oe_async: assert property (output_enable_n |-> &data_oe_n)
      else $error("drivers on with output enable high");
   chk_lanes_same: assert property (data_oe_n == '0 || &data_oe_n)
      else $error("byte lanes driven unevenly");
   chk_flow_read: assert property (rdx && !flow_through_select_n ##1
      (!flow_through_select_n && !output_enable_n) |-> data_oe_n == '0)
      else $error("flow-through read not driven");
   chk_pipe_read: assert property (rdx && flow_through_select_n ##1
      (flow_through_select_n && !wr && !desel && !sleep_request) ##1
      (flow_through_select_n && !output_enable_n) |-> data_oe_n == '0)
      else $error("pipelined read not driven");
   chk_sleep_off: assert property (sleep_request |=> &data_oe_n)
      else $error("drivers on in sleep");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
endmodule // sbs_checker

// File: verif/sbs_ctl_model.sv
// Controller-side model of the shared data wire
module sbs_ctl_model #(
   parameter int W     = 36,
   parameter int LANES = 4
) (
   // Clock
   input  wire logic             aclk,
   // Device side
   input  wire logic [W-1:0]     data_out,
   input  wire logic [LANES-1:0] data_oe_n,
   // Controller side
   input  wire logic             drv,
   input  wire logic [W-1:0]     wval,
   output logic      [W-1:0]     data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] float_pat = '0;

   // Released wire wanders every clock
   always @(posedge aclk) begin
      float_pat <= {float_pat[W-2:0], ~float_pat[W-1]};
   end

   // Device wins; controller drives only write data
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!data_oe_n[i / (W / LANES)])
            data_in[i] = data_out[i];
         else if (drv)
            data_in[i] = wval[i];
         else
            data_in[i] = float_pat[i];
      end
   end
endmodule // sbs_ctl_model

// File: verif/testbench.sv
// Self-checking bench of the burst SRAM control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 6;
   localparam int W  = 36;
   localparam logic [5:0] RDX = 6'h13, WRX = 6'h15, NXT = 6'h16;
   localparam logic [5:0] CUR = 6'h17, DES = 6'h1D, NXH = 6'h1E;
   localparam logic [5:0] UNS = 6'h05, DUM = 6'h36;
   localparam logic [1:0] WA = 2'h1, WB = 2'h2, RD = 2'h3;
   localparam logic [W-1:0] PV = 36'hA_BCDE_F012, QV = 36'hC_0FFE_E123;
   logic [W-1:0] dd [4] = '{36'h1_1111_1111, 36'h2_2222_2222,
                            36'h3_3333_3333, 36'h4_4444_4444};
   logic          aclk = 1'b0, aresetn = 1'b0, drv = 1'b0;
   logic [AW-1:0] addr = '0;
   logic          chip_select_low = 1'b1, chip_select_high = 1'b1;
   // Idle pins form a deselect, so the bus starts released
   logic          proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b0;
   logic          burst_step_n = 1'b1, global_write_n = 1'b1;
   logic          byte_write_enable_n = 1'b1, output_enable_n = 1'b0;
   logic [3:0]    lane_enable_n = 4'hF, data_oe_n;
   logic          linear_order_n = 1'b0, flow_through_select_n = 1'b0;
   logic          sleep_request = 1'b0;
   logic [W-1:0]  data_in, data_out, wval = '0;
   logic [7:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]   s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]    s_axi_wstrb = 4'hF;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic          s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic          s_axi_rready = 1'b0;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic          s_axi_arready, s_axi_rvalid;
   int            miscompares = 0, comparisons = 0;

   sbs_top #(.ADDR_W(AW)) DUT (.aclk, .aresetn, .addr, .chip_select_low,
      .chip_select_high, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
      .burst_step_n, .global_write_n, .byte_write_enable_n, .lane_enable_n,
      .output_enable_n, .linear_order_n, .flow_through_select_n,
      .sleep_request, .data_in, .data_out, .data_oe_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   sbs_ctl_model #(.W(W), .LANES(4)) u_ctl (.aclk, .data_out, .data_oe_n,
      .drv, .wval, .data_in);

   initial forever #12.5 aclk = ~aclk;

   task end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // One SRAM cycle; afterwards the wire shows the previous cycle in flow-through mode, the one before it when pipelined
   task step(input logic [5:0] c, input logic [1:0] w,
             input logic [3:0] le, input logic [AW-1:0] a,
             input logic [W-1:0] d);
      @(posedge aclk);
      {output_enable_n, chip_select_high, chip_select_low,
       proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} <= c;
      {global_write_n, byte_write_enable_n} <= w;
      lane_enable_n <= le;
      addr <= a;
      wval <= d;
      drv <= ~w[1] | (~w[0] & ~&le);
      #2;
   endtask

   task rd_chk(input logic [W-1:0] e);
      chk({data_oe_n, data_in}, {4'h0, e});
   endtask

   task off_chk;
      chk({36'h0, data_oe_n}, 40'hF);
   endtask

   task park;
      step(DES, RD, 4'hF, '0, '0);
      step(DES, RD, 4'hF, '0, '0);
      off_chk;
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d,
               output logic [1:0] r);
      logic ah, wh, ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge aclk);
         ah = !ad && s_axi_awready;
         wh = !wd && s_axi_wready;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         ad = ad | ah;
         wd = wd | wh;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d,
               output logic [1:0] r);
      logic ah;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = s_axi_arready;
         @(posedge aclk);
      end while (ah !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   task t_burst;
      @(posedge aclk);
      linear_order_n <= 1'b0;
      step(WRX, WA, 4'hF, 6'h05, dd[0]);
      for (int i = 1; i < 4; i++)
         step(NXT, WA, 4'hF, '0, dd[i]);
      step(RDX, WB, 4'hF, 6'h05, '0);
      for (int i = 0; i < 4; i++) begin
         step(NXT, RD, 4'hF, '0, '0);
         rd_chk(dd[i]);
      end
      step(DES, RD, 4'hF, '0, '0);
      rd_chk(dd[0]);
      park;
      $display("t_burst done");
   endtask

   task t_inter;
      @(posedge aclk);
      linear_order_n <= 1'b1;
      step(WRX, RD, 4'hF, 6'h05, '0);
      for (int i = 0; i < 4; i++) begin
         step(NXH, RD, 4'hF, '0, '0);
         rd_chk(dd[(4 - i) % 4]);
      end
      step(CUR, RD, 4'hF, '0, '0);
      rd_chk(dd[0]);
      step(DES, RD, 4'hF, '0, '0);
      rd_chk(dd[0]);
      park;
      $display("t_inter done");
   endtask

   task t_bytes;
      @(posedge aclk);
      linear_order_n <= 1'b0;
      step(WRX, WB, 4'hE, 6'h05, PV);
      step(CUR, WB, 4'h7, '0, PV);
      step(CUR, WB, 4'hF, '0, '0);
      off_chk;
      step(DES, RD, 4'hF, '0, '0);
      rd_chk({PV[35:27], dd[0][26:9], PV[8:0]});
      step(UNS, WA, 4'hF, 6'h05, '1);
      step(RDX, RD, 4'hF, 6'h05, '0);
      off_chk;
      step(DES, RD, 4'hF, '0, '0);
      rd_chk({PV[35:27], dd[0][26:9], PV[8:0]});
      park;
      $display("t_bytes done");
   endtask

   task t_pipe;
      @(posedge aclk);
      flow_through_select_n <= 1'b1;
      step(RDX, RD, 4'hF, 6'h06, '0);
      step(NXT, RD, 4'hF, '0, '0);
      off_chk;
      step(NXT, RD, 4'hF, '0, '0);
      rd_chk(dd[1]);
      step(DUM, RD, 4'hF, '0, '0);
      off_chk;
      step(DUM, WA, 4'hF, '0, QV);
      step(RDX, RD, 4'hF, 6'h06, '0);
      step(CUR, RD, 4'hF, '0, '0);
      step(DES, RD, 4'hF, '0, '0);
      rd_chk(QV);
      park;
      @(posedge aclk);
      flow_through_select_n <= 1'b0;
      $display("t_pipe done");
   endtask

   task t_regs;
      logic [31:0] v;
      logic [1:0]  r;
      @(posedge aclk);
      sleep_request <= 1'b1;
      step(RDX, RD, 4'hF, '0, '0);
      step(DES, RD, 4'hF, '0, '0);
      off_chk;
      @(posedge aclk);
      sleep_request <= 1'b0;
      axi_rd(sbs_pkg::OFF_CTRL, v, r);
      chk({6'h0, r, v}, {6'h0, sbs_pkg::RESP_OKAY, 32'h0});
      axi_wr(sbs_pkg::OFF_CTRL, 32'h1, r);
      chk({38'h0, r}, {38'h0, sbs_pkg::RESP_OKAY});
      step(CUR, RD, 4'hF, '0, '0);
      step(CUR, RD, 4'hF, '0, '0);
      axi_rd(sbs_pkg::OFF_STATUS, v, r);
      chk({34'h0, v[10:8], v[6:4]}, 40'h4);
      axi_wr(sbs_pkg::OFF_CTRL, 32'h0, r);
      chk({38'h0, r}, {38'h0, sbs_pkg::RESP_OKAY});
      axi_rd(8'h08, v, r);
      chk({6'h0, r, v}, {6'h0, sbs_pkg::RESP_SLVERR, 32'h0});
      $display("t_regs done");
   endtask

   initial begin
      #100000;
      miscompares++;
      end_sim;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_burst;
      t_inter;
      t_bytes;
      t_pipe;
      t_regs;
      end_sim;
   end
endmodule // testbench

bind sbs_top sbs_checker #(.LANES(LANES)) u_chk (.aclk, .aresetn,
   .chip_select_low, .chip_select_high, .proc_addr_strobe_n,
   .ctrl_addr_strobe_n, .global_write_n, .byte_write_enable_n,
   .lane_enable_n, .output_enable_n, .flow_through_select_n,
   .sleep_request, .data_oe_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid);
